//--- rtl/sbrc_pkg.sv
// Summary of operation
// - Software loads counter with count minus one; that write starts a block receive.
// - Each received byte during an active receive decrements the counter by one, except a byte arriving in the same cycle as a counter write.
// - Reading the counter mid-transfer returns the remaining length minus one.
// - Count is a ten-bit field in bits 9:0; full value means 1024 bytes.
// - After completion the field reads all ones until software writes it again.
// - Transmit address register is readable and writable at its fixed address.
package sbrc_pkg;
  localparam logic [15:0] SBRC_TX_ADDR_OFS = 16'hc07c;
  localparam logic [15:0] SBRC_RX_CNT_OFS = 16'hc080;
  localparam logic [15:0] SBRC_STATUS_OFS = 16'hc084;
  localparam int SBRC_CNT_W = 10;
  localparam logic [9:0] SBRC_CNT_DONE = 10'h3ff;
  localparam logic [9:0] SBRC_CNT_RST = 10'h3ff;
  localparam logic [15:0] SBRC_TX_ADDR_RST = 16'h0000;
  localparam int SBRC_BUSY_BIT = 0;

  typedef enum logic [0:0] {
    SBRC_IDLE = 1'b0,
    SBRC_RECV = 1'b1
  } sbrc_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } sbrc_req_s;
endpackage : sbrc_pkg

//--- rtl/sbrc_counter.sv
`timescale 1ns/100ps
`default_nettype none
module sbrc_counter
  import sbrc_pkg::*;
#(
  parameter int CNT_W = SBRC_CNT_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [CNT_W-1:0] load_value,
  input wire logic byte_strobe,
  output logic [CNT_W-1:0] count,
  output logic busy,
  output logic done_pulse
);
  sbrc_state_e state;
  sbrc_state_e next_state;
  logic [CNT_W-1:0] next_count;
  wire logic step = (state == SBRC_RECV) && byte_strobe && !load;
  wire logic last = step && (count == '0);

  assign busy = (state == SBRC_RECV);
  assign next_state = load ? SBRC_RECV : (last ? SBRC_IDLE : state);
  assign next_count = load ? load_value : (step ? count - 1'b1 : count);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SBRC_IDLE;
      count <= CNT_W'(SBRC_CNT_RST);
      done_pulse <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count; // wraps 0 to all ones
      done_pulse <= last;
    end
  end
endmodule // sbrc_counter
`default_nettype wire

//--- rtl/sbrc_top.sv
`timescale 1ns/100ps
`default_nettype none
module sbrc_top
  import sbrc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rx_byte_valid,
  output logic [15:0] tx_block_address,
  output logic rx_busy,
  output logic rx_done
);
  // ==========================================
  // Reset release
  logic rst_q1;
  logic rst_n;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // ==========================================
  // Byte strobe synchroniser
  logic rxv_q1;
  logic rxv_q2;
  logic rxv_q3;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxv_q1 <= 1'b0;
      rxv_q2 <= 1'b0;
      rxv_q3 <= 1'b0;
    end else begin
      rxv_q1 <= rx_byte_valid;
      rxv_q2 <= rxv_q1;
      rxv_q3 <= rxv_q2;
    end
  end
  wire logic byte_strobe = rxv_q2 && !rxv_q3;

  // ==========================================
  // AHB-Lite address phase capture
  sbrc_req_s req;
  wire logic addr_phase = hsel && hready && htrans[1];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req <= '0;
    end else if (hready) begin
      req.wr <= addr_phase && hwrite;
      req.rd <= addr_phase && !hwrite;
      req.addr <= haddr[15:0];
      req.wdata <= '0;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ==========================================
  // Register decode
  wire logic hit_tx = (req.addr == SBRC_TX_ADDR_OFS);
  wire logic hit_cnt = (req.addr == SBRC_RX_CNT_OFS);
  wire logic hit_st = (req.addr == SBRC_STATUS_OFS);
  wire logic wr_tx = req.wr && hit_tx;
  wire logic wr_cnt = req.wr && hit_cnt;

  // ==========================================
  // Transmit address register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_block_address <= SBRC_TX_ADDR_RST;
    end else if (wr_tx) begin
      tx_block_address <= hwdata[15:0];
    end
  end

  // ==========================================
  // Receive counter
  logic [SBRC_CNT_W-1:0] count;
  logic done_pulse;
  sbrc_counter #(
    .CNT_W(SBRC_CNT_W)
  ) u_counter (
    .clk(clk),
    .rst_n(rst_n),
    .load(wr_cnt),
    .load_value(hwdata[SBRC_CNT_W-1:0]), // reserved bits ignored
    .byte_strobe(byte_strobe),
    .count(count),
    .busy(rx_busy),
    .done_pulse(done_pulse)
  );
  assign rx_done = done_pulse;

  // ==========================================
  // Read data
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_tx) begin
      rd_mux = {16'h0000, tx_block_address};
    end else if (hit_cnt) begin
      rd_mux = {22'h0, count};
    end else if (hit_st) begin
      rd_mux[SBRC_BUSY_BIT] = rx_busy;
    end
  end
  assign hrdata = req.rd ? rd_mux : 32'h0000_0000;
endmodule // sbrc_top
`default_nettype wire

//--- dv/sbrc_chk.sv
`timescale 1ns/100ps
`default_nettype none
module sbrc_chk
  import sbrc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hrdata,
  input wire logic [15:0] tx_block_address,
  input wire logic rx_busy,
  input wire logic rx_done
);
  logic rd;
  wire ca = hsel && htrans[1] && haddr[15:0] == SBRC_RX_CNT_OFS;
  wire cw = ca && hwrite;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd <= 1'b0;
    end else begin
      rd <= ca && !hwrite;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ======
  // Checks
  chk_busy_load: assert property ($rose(rx_busy) |-> $past(cw, 2)) else $error("load");
  chk_done_end: assert property ($fell(rx_busy) |-> ##[0:1] rx_done) else $error("end");
  chk_done_once: assert property (rx_done |=> !rx_done) else $error("once");
  chk_done_idle: assert property (rx_done |-> !rx_busy) else $error("idle");
  chk_full_idle: assert property (rd && !rx_busy |-> hrdata == {22'h0, SBRC_CNT_DONE}) else $error("f");
  chk_high_zero: assert property (rd |-> hrdata[31:10] == 22'h0) else $error("high");
  chk_tx_write: assert property (!$stable(tx_block_address) |-> $past(hwrite, 2)) else $error("tx");
  cover property (rx_done);
  cover property ($rose(rx_busy));
  cover property (rd && rx_busy);
endmodule // sbrc_chk
bind sbrc_top sbrc_chk i_chk (.*);
`default_nettype wire

//--- dv/sbrc_src.sv
`timescale 1ns/100ps
`default_nettype none
module sbrc_src (
  input wire logic clk,
  output logic rx_byte_valid = 1'h0
);
  // ======
  // Byte source
  task automatic send(int n);
    repeat (n) begin
      rx_byte_valid <= 1'h1;
      repeat (2) @(posedge clk);
      rx_byte_valid <= 1'h0;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule // sbrc_src
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
  import sbrc_pkg::*;
;
  logic clk = 1'h0, resetn = 1'h0, hwrite = 1'h0, hsel = 1'h1, hreadyout, hresp, rx_byte_valid;
  logic rx_busy, rx_done;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [15:0] tx_block_address;
  int bad_count = 0, tests_run = 0;
  always #25 clk = ~clk;
  sbrc_top i_dut (
    .clk(clk),
    .resetn(resetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(3'h2),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .rx_byte_valid(rx_byte_valid),
    .tx_block_address(tx_block_address),
    .rx_busy(rx_busy),
    .rx_done(rx_done)
  );
  sbrc_src i_src (
    .clk(clk),
    .rx_byte_valid(rx_byte_valid)
  );
  // ======
  // Bus cycle and scenarios
  task automatic xfer(logic [15:0] a, logic w, logic [31:0] d);
    {haddr, hwrite, htrans} <= {16'h0, a, w, 2'h2};
    do @(posedge clk); while (hreadyout !== 1'h1);
    {htrans, hwdata} <= {2'h0, d};
    do @(posedge clk); while (hreadyout !== 1'h1);
    q = hrdata;
    tests_run++;
    if (hresp !== 1'h0) begin
      bad_count++;
      $display("MISMATCH %0t response", $time);
    end
    tests_run += !w;
    if (!w && q !== d) begin
      bad_count++;
      $display("MISMATCH %0t read %h", $time, q);
    end
  endtask
  task automatic t_regs;
    xfer(SBRC_RX_CNT_OFS, 1'h0, 32'h3ff);
    xfer(SBRC_TX_ADDR_OFS, 1'h1, 32'ha5c3);
    xfer(SBRC_TX_ADDR_OFS, 1'h0, 32'ha5c3);
    hsel <= 1'h0;
    xfer(SBRC_TX_ADDR_OFS, 1'h1, 32'h5a3c);
    hsel <= 1'h1;
    xfer(SBRC_TX_ADDR_OFS, 1'h0, 32'ha5c3);
    tests_run++;
    if (tx_block_address !== 16'ha5c3) begin
      bad_count++;
      $display("MISMATCH %0t tx address %h", $time, tx_block_address);
    end
    xfer(16'hc0f0, 1'h0, 32'h0);
  endtask
  task automatic t_reset;
    resetn <= 1'h0;
    repeat (2) @(posedge clk);
    tests_run++;
    if ({rx_busy, rx_done, tx_block_address} !== {2'h0, SBRC_TX_ADDR_RST}) begin
      bad_count++;
      $display("MISMATCH %0t reset outputs", $time);
    end
    resetn <= 1'h1;
    repeat (3) @(posedge clk);
    xfer(SBRC_RX_CNT_OFS, 1'h0, 32'h3ff);
  endtask
  task automatic t_recv;
    xfer(SBRC_RX_CNT_OFS, 1'h1, 32'h1);
    xfer(SBRC_STATUS_OFS, 1'h0, 32'h1);
    i_src.send(1);
    xfer(SBRC_RX_CNT_OFS, 1'h0, 32'h0);
    i_src.send(2);
    xfer(SBRC_RX_CNT_OFS, 1'h0, 32'h3ff);
    xfer(SBRC_RX_CNT_OFS, 1'h1, 32'h3ff);
    i_src.send(2);
    xfer(SBRC_RX_CNT_OFS, 1'h0, 32'h3fd);
  endtask
  task automatic complete_run;
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'h1;
    repeat (3) @(posedge clk);
    t_regs;
    t_recv;
    t_reset;
    complete_run;
  end
  initial begin
    #100000;
    bad_count++;
    complete_run;
  end
endmodule // tb
`default_nettype wire
